// [verilog/ddc_pkg.sv]
// Shared constants for the down-conversion and burst output block
package ddc_pkg;
    localparam int SAMPLE_W = 14;
    localparam int OUT_W    = 16;
    localparam int HC_W     = 26;
    localparam int LC_W     = 29;
    localparam int FIFO_W   = 34;
    localparam int FIFO_D   = 16;
    // Register byte offsets
    localparam logic [7:0] REG_MODE    = 8'h00;
    localparam logic [7:0] REG_HC_AB   = 8'h04;
    localparam logic [7:0] REG_LC_AB   = 8'h08;
    localparam logic [7:0] REG_HC_CD   = 8'h0C;
    localparam logic [7:0] REG_LC_CD   = 8'h10;
    localparam logic [7:0] REG_STATUS  = 8'h14;
    // Mode register fields
    localparam int F_MODE_AB = 0;
    localparam int F_MODE_CD = 4;
    localparam int F_NMIX    = 8;
    localparam int F_MIXPOS  = 12;
    localparam int F_HPF     = 13;
    localparam int F_MANUAL  = 14;
    localparam logic [3:0] MODE_0 = 4'h0;
    localparam logic [3:0] MODE_2 = 4'h2;
    localparam logic [3:0] MODE_4 = 4'h4;
    localparam logic [3:0] MODE_5 = 4'h5;
    localparam logic [3:0] MODE_6 = 4'h6;
    localparam logic [3:0] MODE_7 = 4'h7;
    localparam logic [3:0] MODE_8 = 4'h8;
    localparam logic [HC_W-1:0] HC_MAX = 26'h2000000;
    localparam logic [LC_W-1:0] LC_MAX = 29'h10000000;
    localparam logic [HC_W-1:0] HC_DEF = 26'h0000001;
    localparam logic [LC_W-1:0] LC_DEF = 29'h0000003;
    localparam logic [31:0] MODE_RST   = 32'h00000000;
    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;
    typedef enum logic [1:0] {
        B_IDLE = 2'b00,
        B_LOW  = 2'b01,
        B_WAIT = 2'b10,
        B_HIGH = 2'b11
    } burst_e;
endpackage

// [verilog/sample_fifo.sv]
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module sample_fifo #(
    parameter int WIDTH = 34,
    parameter int DEPTH = 16
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_q];

    always_ff @(posedge aclk)
    begin
        if (push)
        begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop)
            begin
                rd_q <= rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// [verilog/ddc_burst.sv]
// Down-conversion and burst output for one channel pair, AXI4-Lite control
`timescale 1ns/1ps
module ddc_burst
(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [7:0]            s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic [ddc_pkg::SAMPLE_W-1:0] adc_sample,
    input  wire logic                  adc_valid,
    input  wire logic                  trigger_pin,
    output logic [ddc_pkg::OUT_W-1:0]  out_i,
    output logic [ddc_pkg::OUT_W-1:0]  out_q,
    output logic                       high_res_marker,
    output logic                       out_valid,
    input  wire logic                  out_ready,
    output logic                       trigger_ready
);
    import ddc_pkg::*;

    // Register bus
    logic [31:0]      mode_q;
    logic [HC_W-1:0]  hc_q [2];
    logic [LC_W-1:0]  lc_q [2];
    logic [7:0]       awaddr_q;
    logic [31:0]      wdata_q;
    logic             aw_have_q;
    logic             w_have_q;
    logic             wr_go;
    logic             dut_fix_q;
    logic             mode_ok;
    logic [3:0]       mode_ab;

    assign mode_ab       = mode_q[F_MODE_AB +: 4];
    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
    assign wr_go         = aw_have_q && w_have_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    // Legal values only; pair modes may differ only when one is burst
    function automatic logic legal(input logic [3:0] m);
        legal = (m == MODE_0) || (m == MODE_2) || (m == MODE_4) ||
                (m == MODE_5) || (m == MODE_6) || (m == MODE_7) ||
                (m == MODE_8);
    endfunction

    function automatic logic pair_ok(input logic [31:0] v);
        logic [3:0] a;
        logic [3:0] c;
        a = v[F_MODE_AB +: 4];
        c = v[F_MODE_CD +: 4];
        pair_ok = legal(a) && legal(c) &&
                  (a == c || a == MODE_8 || c == MODE_8);
    endfunction

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= '0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            else if (wr_go)
            begin
                aw_have_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
            end
            else if (wr_go)
            begin
                w_have_q <= 1'b0;
            end
        end
    end

    assign mode_ok = pair_ok(wdata_q);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode_q       <= MODE_RST;
            hc_q[0]      <= HC_DEF;
            lc_q[0]      <= LC_DEF;
            hc_q[1]      <= HC_DEF;
            lc_q[1]      <= LC_DEF;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
            dut_fix_q    <= 1'b0;
        end
        else
        begin
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= RESP_OKAY;
                unique case (awaddr_q)
                    REG_MODE:
                    begin
                        if (mode_ok)
                        begin
                            mode_q <= wdata_q;
                        end
                        else
                        begin
                            s_axi_bresp <= RESP_SLVERR;
                        end
                    end
                    REG_HC_AB: hc_q[0] <= wdata_q[HC_W-1:0];
                    REG_LC_AB: lc_q[0] <= wdata_q[LC_W-1:0];
                    REG_HC_CD: hc_q[1] <= wdata_q[HC_W-1:0];
                    REG_LC_CD: lc_q[1] <= wdata_q[LC_W-1:0];
                    default:   s_axi_bresp <= RESP_SLVERR;
                endcase
            end
            else if (s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
            // Range and duty check, both pairs
            if (!wr_go)
            begin
                dut_fix_q <= 1'b0;
                for (int p = 0; p < 2; p++)
                begin
                    if (hc_q[p] == '0 || hc_q[p] > HC_MAX ||
                        lc_q[p] == '0 || lc_q[p] > LC_MAX ||
                        {3'b000, hc_q[p]} * 3 > {2'b00, lc_q[p]})
                    begin
                        hc_q[p]   <= HC_DEF;
                        lc_q[p]   <= LC_DEF;
                        dut_fix_q <= 1'b1;
                    end
                end
            end
        end
    end

    // Burst sequencer for the AB pair
    burst_e           bst_q;
    logic [LC_W-1:0]  run_q;
    logic [HC_W-1:0]  hc_live_q;
    logic [LC_W-1:0]  lc_live_q;
    logic             trig_s1_q;
    logic             trig_s2_q;
    logic             trig_s3_q;
    logic             trig_edge;
    logic             manual;
    logic             step;
    logic             burst_on;
    logic             fifo_ready;

    assign manual    = mode_q[F_MANUAL];
    assign burst_on  = (mode_ab == MODE_8);
    assign step      = adc_valid && fifo_ready;
    assign trig_edge = trig_s2_q && !trig_s3_q;
    assign trigger_ready = (bst_q == B_WAIT);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            trig_s1_q <= 1'b0;
            trig_s2_q <= 1'b0;
            trig_s3_q <= 1'b0;
        end
        else
        begin
            trig_s1_q <= trigger_pin;
            trig_s2_q <= trig_s1_q;
            trig_s3_q <= trig_s2_q;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn || !burst_on)
        begin
            bst_q     <= B_IDLE;
            run_q     <= '0;
            hc_live_q <= HC_DEF;
            lc_live_q <= LC_DEF;
        end
        else
        begin
            unique case (bst_q)
                B_IDLE:
                begin
                    bst_q     <= B_LOW;
                    run_q     <= '0;
                    hc_live_q <= hc_q[0];
                    lc_live_q <= lc_q[0];
                end
                B_LOW:
                begin
                    if (step)
                    begin
                        run_q <= run_q + 1'b1;
                        if (run_q + 1'b1 == lc_live_q)
                        begin
                            run_q <= '0;
                            bst_q <= manual ? B_WAIT : B_HIGH;
                        end
                    end
                end
                B_WAIT:
                begin
                    if (trig_edge)
                    begin
                        bst_q <= B_HIGH;
                    end
                end
                B_HIGH:
                begin
                    if (step)
                    begin
                        run_q <= run_q + 1'b1;
                        if (run_q + 1'b1 == {3'b000, hc_live_q})
                        begin
                            // Straight back to a low run, no sample lost
                            bst_q     <= B_LOW;
                            run_q     <= '0;
                            hc_live_q <= hc_q[0];
                            lc_live_q <= lc_q[0];
                        end
                    end
                end
            endcase
        end
    end

    // Mixer phase and decimation datapath
    logic [3:0]                 ph_q;
    logic [1:0]                 dec_q;
    logic signed [SAMPLE_W:0]   s;
    logic signed [SAMPLE_W+1:0] mi;
    logic signed [SAMPLE_W+1:0] mq;
    logic signed [SAMPLE_W+1:0] pi_q;
    logic signed [SAMPLE_W+1:0] pq_q;
    logic signed [SAMPLE_W+2:0] ai;
    logic signed [SAMPLE_W+2:0] aq;
    logic signed [SAMPLE_W+2:0] hi_q;
    logic signed [SAMPLE_W+2:0] hq_q;
    logic signed [3:0]          nmix;
    logic [3:0]                 fstep;
    logic                       zero_q;
    logic [FIFO_W-1:0]          fifo_in;
    logic                       fifo_in_valid;
    logic                       sample_en;
    logic [OUT_W-1:0]           ri;
    logic [OUT_W-1:0]           rq;

    assign nmix = mode_q[F_NMIX +: 4];
    assign s    = {adc_sample[SAMPLE_W-1], adc_sample};
    // Phase step per sample in sixteenths; sign picks spectral orientation
    always_comb
    begin
        fstep = 4'h0;
        if (mode_ab == MODE_0)
        begin
            fstep = mode_q[F_MIXPOS] ? 4'h4 : 4'hC;
        end
        else if (mode_ab >= MODE_4 && mode_ab <= MODE_7)
        begin
            fstep = nmix;
        end
    end

    // Coarse NCO: quadrant rotation of the sample, sign flips per quadrant
    always_comb
    begin
        mi = '0;
        mq = '0;
        unique case (ph_q[3:2])
            2'b00: begin mi = s;  mq = '0; end
            2'b01: begin mi = '0; mq = -s; end
            2'b10: begin mi = -s; mq = '0; end
            2'b11: begin mi = '0; mq = s;  end
        endcase
        if (mode_ab == MODE_2)
        begin
            mi = mode_q[F_HPF] && ph_q[2] ? -s : s;
            mq = '0;
        end
    end

    // Two-tap half-band stage: sum pairs, keep one of two
    assign ai = pi_q + mi;
    assign aq = pq_q + mq;
    assign sample_en = adc_valid && fifo_ready;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ph_q   <= '0;
            dec_q  <= '0;
            pi_q   <= '0;
            pq_q   <= '0;
            hi_q   <= '0;
            hq_q   <= '0;
            zero_q <= 1'b0;
        end
        else if (sample_en)
        begin
            ph_q  <= (mode_ab == MODE_2) ? ph_q + 4'h4 : ph_q + fstep;
            pi_q  <= mi;
            pq_q  <= mq;
            dec_q <= dec_q + 1'b1;
            if (dec_q[0])
            begin
                // Second halving stage sums two first-stage results only
                hi_q <= (mode_ab == MODE_6 && dec_q[1]) ? ai + hi_q : ai;
                hq_q <= (mode_ab == MODE_6 && dec_q[1]) ? aq + hq_q : aq;
            end
            zero_q <= !zero_q;
        end
    end

    // Second fs/8 mix to real: rotate complex result and keep I
    always_comb
    begin
        ri = hi_q[SAMPLE_W+2 -: OUT_W];
        rq = hq_q[SAMPLE_W+2 -: OUT_W];
        if (mode_ab == MODE_4 || mode_ab == MODE_7)
        begin
            ri = dec_q[1] ? -hq_q[SAMPLE_W+2 -: OUT_W]
                          : hi_q[SAMPLE_W+2 -: OUT_W];
            rq = '0;
        end
        if (mode_ab == MODE_2)
        begin
            rq = '0;
        end
    end

    // Output selection into the FIFO
    always_comb
    begin
        fifo_in_valid = 1'b0;
        fifo_in = '0;
        if (burst_on)
        begin
            // Low-res keeps top 9 bits, high-res all 14
            fifo_in_valid = adc_valid && (bst_q == B_LOW || bst_q == B_HIGH);
            fifo_in = {(bst_q == B_HIGH), 1'b0,
                       (bst_q == B_HIGH) ? {adc_sample, 2'b00}
                                         : {adc_sample[13:5], 7'h00},
                       16'h0000};
        end
        else if (mode_ab == MODE_7)
        begin
            fifo_in_valid = adc_valid;
            fifo_in = {2'b00, zero_q ? 16'h0000 : ri, 16'h0000};
        end
        else
        begin
            fifo_in_valid = adc_valid && dec_q[0] &&
                            (mode_ab != MODE_6 || dec_q[1]);
            fifo_in = {2'b00, ri, rq};
        end
    end

    logic [FIFO_W-1:0] fifo_out;

    sample_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_D)
    ) u_fifo (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .in_data   (fifo_in),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_ready),
        .out_data  (fifo_out),
        .out_valid (out_valid),
        .out_ready (out_ready)
    );

    assign out_i           = fifo_out[2*OUT_W-1:OUT_W];
    assign out_q           = fifo_out[OUT_W-1:0];
    assign high_res_marker = fifo_out[FIFO_W-1];

    // Read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            unique case (s_axi_araddr)
                REG_MODE:   s_axi_rdata <= mode_q;
                REG_HC_AB:  s_axi_rdata <= {6'h00, hc_q[0]};
                REG_LC_AB:  s_axi_rdata <= {3'h0, lc_q[0]};
                REG_HC_CD:  s_axi_rdata <= {6'h00, hc_q[1]};
                REG_LC_CD:  s_axi_rdata <= {3'h0, lc_q[1]};
                REG_STATUS: s_axi_rdata <= {27'h0, dut_fix_q,
                                            trigger_ready, bst_q, out_valid};
                default:
                begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence low_done;
        bst_q == B_LOW && step && run_q + 1'b1 == lc_live_q;
    endsequence

    chk_manual_wait: assert property (
        (low_done and manual) |=> bst_q == B_WAIT)
        else $error("manual burst did not wait");
    chk_auto_high: assert property (
        (low_done and !manual) |=> bst_q == B_HIGH)
        else $error("auto burst did not go high");
    chk_cycle_low: assert property (
        bst_q == B_IDLE && burst_on |=> bst_q == B_LOW)
        else $error("cycle not started low");
    chk_duty_fix: assert property (
        {3'b000, hc_q[0]} * 3 > {2'b00, lc_q[0]} && !wr_go
        |=> hc_q[0] == HC_DEF && lc_q[0] == LC_DEF)
        else $error("duty limit not enforced");
    chk_range_hi: assert property (
        ##1 !$past(wr_go) |-> hc_q[0] <= HC_MAX)
        else $error("high count range");
    chk_mode_legal: assert property (
        pair_ok(mode_q))
        else $error("illegal mode held");
    chk_wait_hold: assert property (
        burst_on && bst_q == B_WAIT && !trig_edge |=> bst_q == B_WAIT)
        else $error("left wait without trigger");
    chk_burst_bypass: assert property (
        burst_on && bst_q == B_HIGH && fifo_in_valid |-> fifo_in[FIFO_W-1])
        else $error("marker missing on high run");
endmodule

// [tb/link_sink.sv]
// Receiving end of the sample stream, stalling at random
`timescale 1ns/1ps
module link_sink (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic [ddc_pkg::OUT_W-1:0] out_i,
    input  wire logic                      high_res_marker,
    input  wire logic                      out_valid,
    input  wire logic                      hold,
    output logic                           out_ready
);
    import ddc_pkg::*;
    logic [OUT_W-1:0] val_q [$];
    logic             mark_q [$];
    int               mark_cnt = 0;
    int               seed = 43;
    initial out_ready = 1'b0;
    // Logs every taken sample; reset empties the log
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            val_q.delete();
            mark_q.delete();
            mark_cnt = 0;
        end
        else if (out_valid === 1'b1 && out_ready)
        begin
            val_q.push_back(out_i);
            mark_q.push_back(high_res_marker);
            mark_cnt = mark_cnt + (high_res_marker === 1'b1);
        end
        out_ready <= !hold && ($random(seed) % 4 != 0);
    end
endmodule

// [tb/tb_ddc_burst.sv]
// Self-checking bench for the down-conversion and burst block
`timescale 1ns/1ps
module tb_ddc_burst;
    import ddc_pkg::*;
    logic                aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0;
    logic                bready = 0, arvalid = 0, rready = 0;
    logic                adc_valid = 0, trigger_pin = 0, hold = 0;
    logic [7:0]          awaddr = 0, araddr = 0;
    logic [31:0]         wdata = 0, m, rdata;
    logic [SAMPLE_W-1:0] adc_sample = 0;
    logic                awready, wready, bvalid, arready, rvalid;
    logic                out_valid, out_ready, mark, trigger_ready;
    logic [1:0]          bresp, rresp;
    logic [OUT_W-1:0]    out_i, out_q;
    int                  q_nz = 0;
    int                  seed = 43, error_cnt = 0, checks = 0;
    int                  i, k, h, l;
    logic [3:0]          dm [6] = '{MODE_0, MODE_2, MODE_4,
                                    MODE_5, MODE_6, MODE_7};
    int                  dn [6] = '{12, 12, 12, 12, 6, 24};
    always #10 aclk = ~aclk;
    ddc_burst uut (
        .aclk            (aclk),
        .aresetn         (aresetn),
        .s_axi_awaddr    (awaddr),
        .s_axi_awvalid   (awvalid),
        .s_axi_awready   (awready),
        .s_axi_wdata     (wdata),
        .s_axi_wstrb     (4'hF),
        .s_axi_wvalid    (wvalid),
        .s_axi_wready    (wready),
        .s_axi_bresp     (bresp),
        .s_axi_bvalid    (bvalid),
        .s_axi_bready    (bready),
        .s_axi_araddr    (araddr),
        .s_axi_arvalid   (arvalid),
        .s_axi_arready   (arready),
        .s_axi_rdata     (rdata),
        .s_axi_rresp     (rresp),
        .s_axi_rvalid    (rvalid),
        .s_axi_rready    (rready),
        .adc_sample      (adc_sample),
        .adc_valid       (adc_valid),
        .trigger_pin     (trigger_pin),
        .out_i           (out_i),
        .out_q           (out_q),
        .high_res_marker (mark),
        .out_valid       (out_valid),
        .out_ready       (out_ready),
        .trigger_ready   (trigger_ready)
    );
    link_sink snk (
        .aclk            (aclk),
        .aresetn         (aresetn),
        .out_i           (out_i),
        .high_res_marker (mark),
        .out_valid       (out_valid),
        .hold            (hold),
        .out_ready       (out_ready)
    );
    // Counts taken words whose imaginary part is not zero
    always @(posedge aclk)
    begin
        if (!aresetn)
            q_nz = 0;
        else if (out_valid === 1'b1 && out_ready === 1'b1 && out_q !== '0)
            q_nz++;
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task report_and_stop;
        $display("Counts: %0d checks, %0d errors", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    function logic exp_mark(int n, int hc, int lc);
        return (n % (hc + lc)) >= lc;
    endfunction
    task rst;
        aresetn <= 0;
        repeat (10) @(posedge aclk);
        aresetn <= 1;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w;
        aw = 0;
        w = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'b111;
        while (!(aw && w))
        begin
            @(posedge aclk);
            aw = aw | (awready === 1'b1);
            w = w | (wready === 1'b1);
            if (aw) awvalid <= 0;
            if (w) wvalid <= 0;
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        bready <= 0;
        chk("bresp", er, bresp);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 0;
        while (rvalid !== 1'b1) @(posedge aclk);
        rready <= 0;
        chk("rdata", ed, rdata);
        chk("rresp", er, rresp);
    endtask
    // Sends n samples with random gaps between them
    task feed(input int n);
        int c;
        bit v;
        c = 0;
        while (c < n)
        begin
            @(posedge aclk);
            v = ($random(seed) % 3 != 0);
            adc_valid <= v;
            adc_sample <= SAMPLE_W'($random(seed));
            c += v;
        end
        @(posedge aclk);
        adc_valid <= 0;
    endtask
    // Waits until the output has been quiet for a while
    task settle;
        int z;
        z = 0;
        while (z < 8)
        begin
            @(posedge aclk);
            z = (out_valid === 1'b1) ? 0 : z + 1;
        end
    endtask
    initial
    begin
        repeat (10000) @(posedge aclk);
        error_cnt++;
        $display("[ERR] watchdog expected done seen hang");
        report_and_stop();
    end
    initial
    begin
        rst();
        rd(REG_MODE, MODE_RST, RESP_OKAY);
        rd(REG_HC_AB, 32'(HC_DEF), RESP_OKAY);
        rd(REG_LC_CD, 32'(LC_DEF), RESP_OKAY);
        rd(8'h18, 32'h0, RESP_SLVERR);
        wr(8'h18, 32'h1, RESP_SLVERR);
        wr(REG_LC_AB, 32'h9, RESP_OKAY);
        wr(REG_HC_AB, 32'h3, RESP_OKAY);
        rd(REG_HC_AB, 32'h3, RESP_OKAY);
        rd(REG_HC_CD, 32'(HC_DEF), RESP_OKAY);
        wr(REG_HC_AB, 32'h4, RESP_OKAY);
        rd(REG_HC_AB, 32'(HC_DEF), RESP_OKAY);
        rd(REG_LC_AB, 32'(LC_DEF), RESP_OKAY);
        wr(REG_LC_CD, 32'(LC_MAX), RESP_OKAY);
        rd(REG_LC_CD, 32'(LC_MAX), RESP_OKAY);
        wr(REG_LC_CD, 32'(LC_MAX) + 1, RESP_OKAY);
        rd(REG_LC_CD, 32'(LC_DEF), RESP_OKAY);
        wr(REG_MODE, 32'h1, RESP_SLVERR);
        wr(REG_MODE, 32'h50, RESP_SLVERR);
        rd(REG_MODE, MODE_RST, RESP_OKAY);
        $display("Test registers done");
        for (i = 0; i < 6; i++)
        begin
            rst();
            m = {18'h0, 6'($random(seed)), MODE_8, dm[i]};
            wr(REG_MODE, m, RESP_OKAY);
            rd(REG_MODE, m, RESP_OKAY);
            feed(24);
            settle();
            chk("outputs", dn[i], snk.val_q.size());
            if (dm[i] inside {MODE_2, MODE_4, MODE_7})
                chk("imag zero", 32'h0, q_nz);
        end
        for (k = 1; k < 24; k += 2)
            chk("zero pad", 32'h0, 32'(snk.val_q[k]));
        $display("Test decimation done");
        for (i = 0; i < 2; i++)
        begin
            rst();
            h = i ? 2 : 1;
            l = i ? 7 : 3;
            wr(REG_LC_AB, l, RESP_OKAY);
            wr(REG_HC_AB, h, RESP_OKAY);
            wr(REG_MODE, {24'h0, MODE_8, MODE_8}, RESP_OKAY);
            feed(36);
            settle();
            chk("burst count", 32'd36, snk.val_q.size());
            chk("burst imag", 32'h0, q_nz);
            for (k = 0; k < 36; k++)
                chk("marker", exp_mark(k, h, l), snk.mark_q[k]);
        end
        $display("Test burst done");
        rst();
        wr(REG_MODE, {17'h0, 1'b1, 6'h0, MODE_8, MODE_8}, RESP_OKAY);
        feed(3);
        for (k = 0; k < 50 && trigger_ready !== 1'b1; k++) @(posedge aclk);
        chk("trig ready", 32'h1, trigger_ready);
        feed(4);
        settle();
        chk("no high", 32'h0, snk.mark_cnt);
        trigger_pin <= 1;
        repeat (4) @(posedge aclk);
        trigger_pin <= 0;
        feed(4);
        settle();
        chk("one high", 32'h1, snk.mark_cnt);
        $display("Test trigger done");
        rst();
        wr(REG_MODE, {24'h0, MODE_8, MODE_8}, RESP_OKAY);
        hold <= 1;
        feed(24);
        repeat (8) @(posedge aclk);
        chk("full valid", 32'h1, out_valid);
        hold <= 0;
        settle();
        chk("fifo kept", FIFO_D, snk.val_q.size());
        $display("Test fifo done");
        report_and_stop();
    end
endmodule
